//--- include/mss_pkg.sv
// Behaviour
// - Mode field 0..6; mode 0 leaves the drive on its normal keypad command.
// - Modes 1 and 4 run the programmed steps once, then stop the motor.
// - Modes 2 and 5 restart at the first step while run stays active.
// - Modes 3 and 6 run once, then hold final step frequency and direction.
// - Modes 1-3 resume the unfinished step after a stop and restart.
// - Modes 4-6 drop progress on stop and restart from the first step.
// - Step frequency commands 1..15, each 0 to 400 Hz, target of its step.
// - Sixteen step durations 0..15, each 0 to 3600 seconds.
// - Per-step direction: 0 stops output, 1 forward, 2 reverse.
// - Sequencing only while a terminal coded 22 is closed.
// - Step 0 takes its frequency from the keypad setting.
// - Step changes ramp with the selected first or second acc/dec pair.
package mss_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned MS_IN_NS      = 1_000_000;
   localparam int unsigned CYC_PER_MS    = MS_IN_NS / CLK_PERIOD_NS;
   localparam int unsigned MS_PER_SEC    = 1000;

   // ---------------------------------------------------------------
   // Sizes and encodings
   // ---------------------------------------------------------------
   localparam int unsigned NSTEP  = 16;
   localparam int unsigned NTERM  = 6;
   localparam int unsigned FREQ_W = 16;
   localparam int unsigned TIME_W = 12;
   localparam int unsigned DIR_W  = 2;
   localparam int unsigned MODE_W = 3;
   localparam int unsigned FUNC_W = 5;
   localparam int unsigned IDX_W  = 4;
   localparam int unsigned ADR_W  = 8;

   localparam logic [FREQ_W-1:0] FREQ_MAX      = 16'h9C40;
   localparam logic [TIME_W-1:0] TIME_MAX      = 12'h0E10;
   localparam logic [DIR_W-1:0]  DIR_STOP      = 2'h0;
   localparam logic [DIR_W-1:0]  DIR_FWD       = 2'h1;
   localparam logic [DIR_W-1:0]  DIR_REV       = 2'h2;
   localparam logic [FUNC_W-1:0] AUTO_RUN_FUNC = 5'h16;

   localparam logic [MODE_W-1:0] MODE_OFF        = 3'h0;
   localparam logic [MODE_W-1:0] MODE_ONCE_KEEP  = 3'h1;
   localparam logic [MODE_W-1:0] MODE_LOOP_KEEP  = 3'h2;
   localparam logic [MODE_W-1:0] MODE_HOLD_KEEP  = 3'h3;
   localparam logic [MODE_W-1:0] MODE_ONCE_NEW   = 3'h4;
   localparam logic [MODE_W-1:0] MODE_LOOP_NEW   = 3'h5;
   localparam logic [MODE_W-1:0] MODE_HOLD_NEW   = 3'h6;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [ADR_W-1:0] ADR_CTRL      = 8'h00;
   localparam logic [ADR_W-1:0] ADR_KEYPAD    = 8'h04;
   localparam logic [ADR_W-1:0] ADR_TERM      = 8'h08;
   localparam logic [ADR_W-1:0] ADR_ACC1      = 8'h0C;
   localparam logic [ADR_W-1:0] ADR_DEC1      = 8'h10;
   localparam logic [ADR_W-1:0] ADR_ACC2      = 8'h14;
   localparam logic [ADR_W-1:0] ADR_DEC2      = 8'h18;
   localparam logic [ADR_W-1:0] ADR_STATUS    = 8'h1C;
   localparam logic [ADR_W-1:0] ADR_FREQ_OUT  = 8'h20;
   localparam logic [1:0]       ADR_STEP_PAGE = 2'h1;

   localparam int unsigned CTRL_MODE_LSB    = 0;
   localparam int unsigned CTRL_ASEL_BIT    = 4;
   localparam int unsigned STEP_FREQ_LSB    = 0;
   localparam int unsigned STEP_TIME_LSB    = 16;
   localparam int unsigned STEP_DIR_LSB     = 28;
   localparam int unsigned STAT_ELAPSED_LSB = 0;
   localparam int unsigned STAT_STEP_LSB    = 16;
   localparam int unsigned STAT_STATE_LSB   = 20;
   localparam int unsigned STAT_EN_BIT      = 24;
   localparam int unsigned STAT_PROG_BIT    = 25;

   localparam logic [MODE_W-1:0]       RST_MODE   = 3'h0;
   localparam logic [FREQ_W-1:0]       RST_KEYPAD = 16'h0000;
   localparam logic [FREQ_W-1:0]       RST_RATE   = 16'h0001;
   localparam logic [NTERM*FUNC_W-1:0] RST_TERM   = 30'h0000_0000;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [DIR_W-1:0]  dir;
      logic [TIME_W-1:0] secs;
      logic [FREQ_W-1:0] freq;
   } mss_step_t;

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD, ST_DONE} mss_state_t;
endpackage

//--- core/mss_tick.sv
`timescale 1ns/1ps
module mss_tick
   import mss_pkg::*;
#(
   parameter int unsigned CYC_MS = CYC_PER_MS
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic clr_i,
   output logic      ms_tick_o,
   output logic      sec_tick_o
);
   localparam int unsigned CW = $clog2(CYC_MS + 1);

   logic [CW-1:0] cyc_r;
   logic [9:0]    ms_r;

   // Cleared while no step runs, so a step's first second is a full second
   always_ff @(posedge clk_i) begin
      if (rst_i || (ce_i && clr_i)) begin
         cyc_r      <= '0;
         ms_r       <= '0;
         ms_tick_o  <= 1'b0;
         sec_tick_o <= 1'b0;
      end else if (ce_i) begin
         ms_tick_o  <= 1'b0;
         sec_tick_o <= 1'b0;
         if (cyc_r == CW'(CYC_MS - 1)) begin
            cyc_r     <= '0;
            ms_tick_o <= 1'b1;
            if (ms_r == 10'(MS_PER_SEC - 1)) begin
               ms_r       <= '0;
               sec_tick_o <= 1'b1;
            end else begin
               ms_r <= ms_r + 10'h001;
            end
         end else begin
            cyc_r <= cyc_r + CW'(1);
         end
      end
   end

   chk_sec_from_ms: assert property (@(posedge clk_i) disable iff (rst_i)
      sec_tick_o |-> ms_tick_o)
      else $error("second tick without millisecond tick");
endmodule

//--- core/mss_ramp.sv
`timescale 1ns/1ps
module mss_ramp
   import mss_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire logic              ms_tick_i,
   input  wire logic [FREQ_W-1:0] target_i,
   input  wire logic [FREQ_W-1:0] up_rate_i,
   input  wire logic [FREQ_W-1:0] dn_rate_i,
   output logic      [FREQ_W-1:0] freq_o
);
   logic [FREQ_W:0] gap;

   always_comb begin
      gap = (target_i > freq_o) ? {1'b0, target_i} - {1'b0, freq_o}
                                : {1'b0, freq_o} - {1'b0, target_i};
   end

   // Never overshoots: the last slice of a ramp lands exactly on target
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         freq_o <= '0;
      end else if (ce_i && ms_tick_i) begin
         if (target_i > freq_o) begin
            freq_o <= (gap > {1'b0, up_rate_i}) ? freq_o + up_rate_i : target_i;
         end else if (target_i < freq_o) begin
            freq_o <= (gap > {1'b0, dn_rate_i}) ? freq_o - dn_rate_i : target_i;
         end
      end
   end

   chk_ramp_slope: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && ms_tick_i && target_i > freq_o)
      |=> freq_o > $past(freq_o) && freq_o <= $past(target_i))
      else $error("ramp did not step toward a higher target");
endmodule

//--- core/mss_sequencer.sv
`timescale 1ns/1ps
module mss_sequencer
   import mss_pkg::*;
#(
   parameter int unsigned CYC_MS = CYC_PER_MS
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire logic [ADR_W-1:0]  adr_i,
   input  wire logic [31:0]       dat_i,
   input  wire logic              we_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   input  wire logic              run_cmd_i,
   input  wire logic [NTERM-1:0]  terminal_i,
   output logic      [FREQ_W-1:0] freq_o,
   output logic                   forward_rotation_o,
   output logic                   reverse_rotation_o,
   output logic                   seq_active_o,
   output logic      [IDX_W-1:0]  step_o
);
   // ---------------------------------------------------------------
   // Registers and state
   // ---------------------------------------------------------------
   mss_step_t               steps_r [NSTEP];
   logic [MODE_W-1:0]       mode_r;
   logic                    acc_sel_r;
   logic [FREQ_W-1:0]       keypad_r, acc1_r, dec1_r, acc2_r, dec2_r;
   logic [NTERM*FUNC_W-1:0] term_func_r;
   logic [1:0]              run_sync_r;
   logic [NTERM-1:0]        term_s1_r, term_s2_r;
   mss_state_t              state_r;
   logic [IDX_W-1:0]        step_r;
   logic [TIME_W-1:0]       elapsed_r;
   logic                    progress_r;
   logic [FREQ_W-1:0]       target_r;

   logic             run, seq_en, any_step, at_end, bus_req, step_page;
   logic             once_m, loop_m, hold_m, resume_m, start;
   logic [NTERM-1:0] term_hit;
   logic [IDX_W-1:0] first_idx, last_idx, next_idx;
   logic             ramp_tick, sec_tick;
   logic [31:0]      rd_word, wr_word;
   mss_step_t        cur;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [FREQ_W-1:0] fclamp(input logic [FREQ_W-1:0] f);
      return (f > FREQ_MAX) ? FREQ_MAX : f;
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisers and enable terminal
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_sync_r <= '0;
         term_s1_r  <= '0;
         term_s2_r  <= '0;
      end else if (ce_i) begin
         run_sync_r <= {run_sync_r[0], run_cmd_i};
         term_s1_r  <= terminal_i;
         term_s2_r  <= term_s1_r;
      end
   end

   generate
      for (genvar g = 0; g < NTERM; g++) begin : g_term
         assign term_hit[g] = term_s2_r[g] &&
                              (term_func_r[g*FUNC_W +: FUNC_W] == AUTO_RUN_FUNC);
      end
   endgenerate

   assign run      = run_sync_r[1];
   assign seq_en   = (|term_hit) && (mode_r != MODE_OFF);
   assign once_m   = (mode_r == MODE_ONCE_KEEP) || (mode_r == MODE_ONCE_NEW);
   assign loop_m   = (mode_r == MODE_LOOP_KEEP) || (mode_r == MODE_LOOP_NEW);
   assign hold_m   = (mode_r == MODE_HOLD_KEEP) || (mode_r == MODE_HOLD_NEW);
   assign resume_m = (mode_r >= MODE_ONCE_KEEP) && (mode_r <= MODE_HOLD_KEEP);
   assign cur      = steps_r[step_r];
   assign start    = (state_r == ST_IDLE) && seq_en && run && any_step;

   // ---------------------------------------------------------------
   // Step table scan: unused steps carry zero duration
   // ---------------------------------------------------------------
   always_comb begin
      first_idx = '0;
      last_idx  = '0;
      next_idx  = '0;
      any_step  = 1'b0;
      for (int i = NSTEP - 1; i >= 0; i--) begin
         if (steps_r[i].secs != '0) begin
            first_idx = IDX_W'(i);
            if (IDX_W'(i) > step_r) begin
               next_idx = IDX_W'(i);
            end
         end
      end
      for (int i = 0; i < NSTEP; i++) begin
         if (steps_r[i].secs != '0) begin
            last_idx = IDX_W'(i);
            any_step = 1'b1;
         end
      end
   end

   assign at_end = sec_tick && (TIME_W'(elapsed_r + 1'b1) >= cur.secs);

   // ---------------------------------------------------------------
   // Wishbone slave
   // ---------------------------------------------------------------
   assign bus_req   = cyc_i && stb_i && !ack_o;
   assign step_page = (adr_i[7:6] == ADR_STEP_PAGE);
   assign wr_word   = merge(rd_word, dat_i, sel_i);

   always_comb begin
      rd_word = 32'h0000_0000;
      if (step_page) begin
         rd_word = {2'b00, steps_r[adr_i[5:2]]};
      end else begin
         unique case (adr_i)
            ADR_CTRL: begin
               rd_word[CTRL_MODE_LSB +: MODE_W] = mode_r;
               rd_word[CTRL_ASEL_BIT]           = acc_sel_r;
            end
            ADR_KEYPAD:   rd_word[FREQ_W-1:0] = keypad_r;
            ADR_TERM:     rd_word[NTERM*FUNC_W-1:0] = term_func_r;
            ADR_ACC1:     rd_word[FREQ_W-1:0] = acc1_r;
            ADR_DEC1:     rd_word[FREQ_W-1:0] = dec1_r;
            ADR_ACC2:     rd_word[FREQ_W-1:0] = acc2_r;
            ADR_DEC2:     rd_word[FREQ_W-1:0] = dec2_r;
            ADR_STATUS: begin
               rd_word[STAT_ELAPSED_LSB +: TIME_W] = elapsed_r;
               rd_word[STAT_STEP_LSB +: IDX_W]     = step_r;
               rd_word[STAT_STATE_LSB +: 2]        = state_r;
               rd_word[STAT_EN_BIT]                = seq_en;
               rd_word[STAT_PROG_BIT]              = progress_r;
            end
            ADR_FREQ_OUT: rd_word[FREQ_W-1:0] = freq_o;
            default:      rd_word = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= '0;
      end else if (ce_i) begin
         ack_o <= bus_req;
         if (bus_req && !we_i) begin
            dat_o <= rd_word;
         end
      end
   end

   // Frequency and duration writes saturate at the documented maxima instead of wrapping
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_r      <= RST_MODE;
         acc_sel_r   <= 1'b0;
         keypad_r    <= RST_KEYPAD;
         term_func_r <= RST_TERM;
         acc1_r      <= RST_RATE;
         dec1_r      <= RST_RATE;
         acc2_r      <= RST_RATE;
         dec2_r      <= RST_RATE;
         for (int i = 0; i < NSTEP; i++) begin
            steps_r[i] <= '0;
         end
      end else if (ce_i && bus_req && we_i) begin
         if (step_page) begin
            steps_r[adr_i[5:2]].freq <= fclamp(wr_word[STEP_FREQ_LSB +: FREQ_W]);
            steps_r[adr_i[5:2]].secs <= (wr_word[STEP_TIME_LSB +: TIME_W] > TIME_MAX) ?
                                        TIME_MAX : wr_word[STEP_TIME_LSB +: TIME_W];
            steps_r[adr_i[5:2]].dir  <= wr_word[STEP_DIR_LSB +: DIR_W];
         end else begin
            unique case (adr_i)
               ADR_CTRL: begin
                  // Out-of-range codes are ignored, keeping the last legal mode
                  if (wr_word[CTRL_MODE_LSB +: MODE_W] <= MODE_HOLD_NEW) begin
                     mode_r <= wr_word[CTRL_MODE_LSB +: MODE_W];
                  end
                  acc_sel_r <= wr_word[CTRL_ASEL_BIT];
               end
               ADR_KEYPAD: keypad_r    <= fclamp(wr_word[FREQ_W-1:0]);
               ADR_TERM:   term_func_r <= wr_word[NTERM*FUNC_W-1:0];
               ADR_ACC1:   acc1_r      <= wr_word[FREQ_W-1:0];
               ADR_DEC1:   dec1_r      <= wr_word[FREQ_W-1:0];
               ADR_ACC2:   acc2_r      <= wr_word[FREQ_W-1:0];
               ADR_DEC2:   dec2_r      <= wr_word[FREQ_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Sequencer state machine
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r    <= ST_IDLE;
         step_r     <= '0;
         elapsed_r  <= '0;
         progress_r <= 1'b0;
      end else if (ce_i) begin
         unique case (state_r)
            ST_IDLE: begin
               if (start) begin
                  state_r <= ST_RUN;
                  if (!(progress_r && resume_m)) begin
                     step_r    <= first_idx;
                     elapsed_r <= '0;
                  end
                  progress_r <= 1'b1;
               end
            end
            ST_RUN: begin
               if (!seq_en || !run) begin
                  // Sub-second progress of the step is lost on a stop
                  state_r    <= ST_IDLE;
                  progress_r <= resume_m;
               end else if (at_end) begin
                  elapsed_r <= '0;
                  if (step_r >= last_idx) begin
                     if (once_m) begin
                        state_r <= ST_DONE;
                     end else if (loop_m) begin
                        step_r <= first_idx;
                     end else if (hold_m) begin
                        state_r <= ST_HOLD;
                     end
                  end else begin
                     step_r <= next_idx;
                  end
               end else if (sec_tick) begin
                  elapsed_r <= elapsed_r + 1'b1;
               end
            end
            ST_HOLD, ST_DONE: begin
               if (!seq_en || !run) begin
                  state_r    <= ST_IDLE;
                  progress_r <= 1'b0;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Drive command
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         target_r           <= '0;
         forward_rotation_o <= 1'b0;
         reverse_rotation_o <= 1'b0;
         seq_active_o       <= 1'b0;
         step_o             <= '0;
      end else if (ce_i) begin
         seq_active_o <= seq_en;
         step_o       <= step_r;
         if (!seq_en) begin
            target_r           <= keypad_r;
            forward_rotation_o <= run;
            reverse_rotation_o <= 1'b0;
         end else if ((state_r == ST_RUN || state_r == ST_HOLD) && cur.dir != DIR_STOP &&
                      cur.dir <= DIR_REV) begin
            target_r           <= (step_r == '0) ? keypad_r : cur.freq;
            forward_rotation_o <= (cur.dir == DIR_FWD);
            reverse_rotation_o <= (cur.dir == DIR_REV);
         end else begin
            target_r           <= '0;
            forward_rotation_o <= 1'b0;
            reverse_rotation_o <= 1'b0;
         end
      end
   end

   mss_tick #(.CYC_MS(CYC_MS)) u_tick (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .clr_i      (state_r != ST_RUN),
      .ms_tick_o  (),
      .sec_tick_o (sec_tick)
   );

   // Ramp time base runs free, so the output still ramps to zero after a cycle ends
   mss_tick #(.CYC_MS(CYC_MS)) u_ramp_tick (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .clr_i      (1'b0),
      .ms_tick_o  (ramp_tick),
      .sec_tick_o ()
   );

   mss_ramp u_ramp (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .ms_tick_i (ramp_tick),
      .target_i  (target_r),
      .up_rate_i (acc_sel_r ? acc2_r : acc1_r),
      .dn_rate_i (acc_sel_r ? dec2_r : dec1_r),
      .freq_o    (freq_o)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_cycle_end;
      ce_i && state_r == ST_RUN && seq_en && run && at_end && step_r >= last_idx;
   endsequence

   sequence s_restart;
      ce_i && start;
   endsequence

   chk_off_normal: assert property (ce_i && !seq_en |=> state_r == ST_IDLE || !$past(run)
      || $past(state_r) != ST_RUN)
      else $error("sequencer kept running without enable");
   chk_single_stop: assert property (s_cycle_end and once_m |=> state_r == ST_DONE
      ##1 (ce_i && seq_en && run) [*1] |-> target_r == '0)
      else $error("single cycle did not stop");
   chk_periodic_wrap: assert property (s_cycle_end and loop_m
      |=> state_r == ST_RUN && step_r == $past(first_idx) && elapsed_r == '0)
      else $error("periodic cycle did not restart");
   chk_final_hold: assert property (ce_i && state_r == ST_HOLD && seq_en && step_r != '0
      && cur.dir != DIR_STOP && cur.dir <= DIR_REV |=> target_r == $past(cur.freq)
      && forward_rotation_o == ($past(cur.dir) == DIR_FWD)
      && reverse_rotation_o == ($past(cur.dir) == DIR_REV))
      else $error("final step not held");
   chk_resume_step: assert property (s_restart and (progress_r && resume_m)
      |=> step_r == $past(step_r) && elapsed_r == $past(elapsed_r))
      else $error("restart did not resume");
   chk_fresh_start: assert property (s_restart and !resume_m
      |=> step_r == $past(first_idx) && elapsed_r == '0)
      else $error("restart did not begin new cycle");
   chk_step_range: assert property (cur.freq <= FREQ_MAX && cur.secs <= TIME_MAX)
      else $error("step setting out of range");
   chk_dir_stop: assert property (ce_i && seq_en && state_r == ST_RUN && cur.dir == DIR_STOP
      |=> target_r == '0 && !forward_rotation_o && !reverse_rotation_o)
      else $error("stop step still drives");
   chk_keypad_step: assert property (ce_i && seq_en && state_r == ST_RUN && step_r == '0
      && cur.dir == DIR_FWD |=> target_r == $past(keypad_r))
      else $error("step zero ignored keypad frequency");
   chk_second_count: assert property (ce_i && state_r == ST_RUN && seq_en && run && sec_tick
      && !at_end |=> elapsed_r == $past(elapsed_r) + 1'b1 && step_r == $past(step_r))
      else $error("elapsed seconds not counted");
   chk_skip_unused: assert property (ce_i && state_r == ST_RUN && seq_en && run && at_end
      && step_r < last_idx |=> step_r > $past(step_r) && cur.secs != '0)
      else $error("advanced onto an unused step");
endmodule

//--- tb/mss_panel.sv
`timescale 1ns/1ps
module mss_panel
   import mss_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             run_i,
   input  wire logic             close_i,
   output logic                  run_cmd_o,
   output logic      [NTERM-1:0] terminal_o
);
   // Run key and enable terminal are registered independently; run is not gated by the terminal
   always_ff @(posedge clk_i) begin
      run_cmd_o  <= run_i;
      terminal_o <= {5'h00, close_i};
   end
endmodule

//--- tb/mss_sequencer_tb.sv
`timescale 1ns/1ps
module mss_sequencer_tb;
   import mss_pkg::*;
   logic             clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic             run = 1'b0, cls = 1'b0, ack, forward_rotation, reverse_rotation, act, run_cmd;
   logic [ADR_W-1:0] adr = 8'h00;
   logic [31:0]      wdat = 32'h0000_0000, rdat, q;
   logic [FREQ_W-1:0] freq;
   logic [IDX_W-1:0] step;
   logic [NTERM-1:0] term;
   int               miscompares = 0, samples_checked = 0;
   initial forever #4 clk = ~clk;
   mss_panel u_panel (.clk_i(clk), .run_i(run), .close_i(cls), .run_cmd_o(run_cmd),
      .terminal_o(term));
   mss_sequencer #(.CYC_MS(2)) u_dut (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .adr_i(adr),
      .dat_i(wdat), .we_i(we), .sel_i(4'hF), .cyc_i(cyc), .stb_i(stb), .dat_o(rdat),
      .ack_o(ack), .run_cmd_i(run_cmd), .terminal_i(term), .freq_o(freq),
      .forward_rotation_o(forward_rotation), .reverse_rotation_o(reverse_rotation), .seq_active_o(act), .step_o(step));
   // ---------------------------------------------------------------
   // Bus and compare tasks
   // ---------------------------------------------------------------
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checked %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Whole run is about 25k cycles; one second is 2000 cycles here
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      print_verdict;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      wb(1, 8'h0C, 32'h0000_0100);
      wb(1, 8'h10, 32'h0000_0100);
      wb(1, 8'h04, 32'h0000_0BB8);
      wb(1, 8'h08, 32'h0000_0016);
      wb(1, 8'h40, 32'h1001_0000);
      wb(1, 8'h44, 32'h2001_07D0);
      wb(1, 8'h48, 32'h0FFF_FFFF);
      wb(0, 8'h48, 32'h0000_0000);
      chk(q, 32'h0E10_9C40);
      wb(1, 8'h48, 32'h0000_0000);
      wb(0, 8'h30, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      $display("test registers done");
      cls <= 1'b1;
      // Modes 1, 2 and 6 in turn
      for (int m = 1; m <= 6; m += (m == 1) ? 1 : 4) begin
         wb(1, 8'h00, 32'(m));
         run <= 1'b1;
         repeat (1000) @(posedge clk);
         chk({act, forward_rotation, reverse_rotation, step}, {3'b110, 4'h0});
         chk(freq, 32'h0000_0BB8);
         repeat (2000) @(posedge clk);
         chk({forward_rotation, reverse_rotation, step}, {2'b01, 4'h1});
         chk(freq, 32'h0000_07D0);
         repeat (2000) @(posedge clk);
         chk({forward_rotation, reverse_rotation, step}, (m == 1) ? 6'h01 : (m == 2) ? 6'h20 : 6'h11);
         chk(freq, (m == 1) ? 32'h0 : (m == 2) ? 32'h0000_0BB8 : 32'h0000_07D0);
         run <= 1'b0;
         repeat (20) @(posedge clk);
         $display("test cycle mode %0d done", m);
      end
      // Interrupt in step 1; sub-second progress is dropped on resume
      for (int m = 1; m <= 4; m += 3) begin
         wb(1, 8'h00, 32'(m));
         run <= 1'b1;
         repeat (3000) @(posedge clk);
         run <= 1'b0;
         repeat (20) @(posedge clk);
         run <= 1'b1;
         repeat (1000) @(posedge clk);
         chk(step, (m == 1) ? 32'h1 : 32'h0);
         run <= 1'b0;
         repeat (20) @(posedge clk);
         $display("test restart mode %0d done", m);
      end
      // Step 0 made a stop step, mode 4 still selected
      wb(1, 8'h40, 32'h0001_0000);
      run <= 1'b1;
      repeat (1000) @(posedge clk);
      chk({forward_rotation, reverse_rotation, freq}, 32'h0000_0000);
      run <= 1'b0;
      repeat (20) @(posedge clk);
      $display("test stop step done");
      // Second rate pair reaches the keypad value in one millisecond
      wb(1, 8'h14, 32'h0000_0BB8);
      wb(1, 8'h00, 32'h0000_0010);
      run <= 1'b1;
      repeat (20) @(posedge clk);
      chk({act, forward_rotation, reverse_rotation}, 3'b010);
      chk(freq, 32'h0000_0BB8);
      $display("test mode off done");
      print_verdict;
   end
endmodule
